// ### hw/tapd_map.vh
// Constants for the test access port: controller state codes, instruction codes,
// register lengths, capture patterns and scan chain numbers.
// Included by the port design file; holds definitions only.
`ifndef TAPD_MAP_VH
`define TAPD_MAP_VH

// Controller state numbers, as presented on the state output.
`define TAPD_ST_EXIT2_DR 4'h0
`define TAPD_ST_EXIT1_DR 4'h1
`define TAPD_ST_SHIFT_DR 4'h2
`define TAPD_ST_PAUSE_DR 4'h3
`define TAPD_ST_SEL_IR 4'h4
`define TAPD_ST_UPDATE_DR 4'h5
`define TAPD_ST_CAPTURE_DR 4'h6
`define TAPD_ST_SEL_DR 4'h7
`define TAPD_ST_EXIT2_IR 4'h8
`define TAPD_ST_EXIT1_IR 4'h9
`define TAPD_ST_SHIFT_IR 4'ha
`define TAPD_ST_PAUSE_IR 4'hb
`define TAPD_ST_RUN_IDLE 4'hc
`define TAPD_ST_UPDATE_IR 4'hd
`define TAPD_ST_CAPTURE_IR 4'he
`define TAPD_ST_TEST_RESET 4'hf

// Instruction codes.
`define TAPD_IR_EXTEST 4'h0
`define TAPD_IR_SCAN_SEL 4'h2
`define TAPD_IR_SAMPLE 4'h3
`define TAPD_IR_RESTART 4'h4
`define TAPD_IR_INTEST 4'hc
`define TAPD_IR_IDCODE 4'he
`define TAPD_IR_BYPASS 4'hf

// Register lengths, capture patterns and reset values.
`define TAPD_IR_LEN 4
`define TAPD_IR_CAPTURE 4'h1
`define TAPD_IR_RESET `TAPD_IR_IDCODE
`define TAPD_ID_LEN 32
`define TAPD_CHAIN_LEN 5
`define TAPD_CHAIN_CAPTURE 5'h10
`define TAPD_CHAIN_RESET 5'h03
`define TAPD_BYPASS_CAPTURE 1'b0

// Scan chain numbers with a routing meaning.
`define TAPD_CHAIN_DEBUG 5'h01
`define TAPD_CHAIN_ICE 5'h02
`define TAPD_CHAIN_EXT 5'h03
`define TAPD_CHAIN_UNASSIGNED_MSB 4

// Data register path selections.
`define TAPD_DR_BYPASS 3'h0
`define TAPD_DR_IDENT 3'h1
`define TAPD_DR_CHAIN_SEL 3'h2
`define TAPD_DR_CHAIN1 3'h3
`define TAPD_DR_CHAIN2 3'h4
`define TAPD_DR_EXT 3'h5

`endif

// ### hw/tapd_port.v
// Test access port: controller, instruction register and decode, bypass,
// identification and chain-select registers, and serial routing of the scan chains.
// Assumes all inputs are synchronous to mclk and that debug_clock_enable qualifies
// every step of the port; the scan chains themselves live outside this module.
//
// Function
// R1 - Instruction register is four bits wide and carries no parity bit.
// R2 - Capture-instruction state loads the fixed pattern 0001 into the instruction register.
// R3 - Shift-instruction moves the instruction register, least significant bit first.
// R4 - Update-instruction makes the shifted value the current instruction.
// R5 - Port reset makes the identification-read instruction current.
// R6 - Inputs sampled and data-out changed only on enabled rising edges; the code forwards data-in to the external chain on every clock.
// R7 - Code 0000 routes the external chain between scan-out and scan-in.
// R8 - Controller must preload the boundary register with sample/preload before tests.
// R9 - Code 0010 selects five-bit chain-select register, capturing 10000, shifting chain number.
// R10 - Update-data under chain-select activates the chain; reset selects chain 3.
// R11 - Code 1100 connects selected chain and puts cells in test mode.
// R12 - Internal test captures cell values then shifts them out while new enters.
// R13 - Code 1110 connects the 32-bit identification register with cells in system mode.
// R14 - Identification register captures the identification pins; nothing programmable.
// R15 - Identification register ignores update-data and has no parallel output.
// R16 - Code 1111 inserts a one-bit bypass capturing 0, one clock delay.
// R17 - Unassigned codes act as bypass; bypass register ignores update-data.
// R18 - Code 0100 behaves exactly like bypass on the serial path.
// R19 - Restart instruction current makes the processor leave debug on entering idle.
// R20 - Selected data register advances one bit per enabled clock.
// R21 - Integrator ties the least significant identification bit to 1.
// R22 - External chains may be selected while internal test is current.
// R23 - Controller pulses test reset low then high; held low disables the port.
// R24 - Current controller state number appears on the four-bit state output.
// R25 - External chain routed for chain 3 or any number 16 to 31.
// R26 - Controller follows the sixteen-state boundary-scan machine on enabled edges.

`include "tapd_map.vh"

`default_nettype none

module tapd_port #(
	parameter IR_LEN = `TAPD_IR_LEN,
	parameter ID_LEN = `TAPD_ID_LEN,
	parameter CHAIN_LEN = `TAPD_CHAIN_LEN
) (
	input wire mclk,
	input wire srst,
	input wire test_reset_n,
	input wire debug_clock_enable,
	input wire serial_data_in,
	input wire mode_select_in,
	input wire [ID_LEN-1:0] ident_value_in,
	input wire ext_chain_scan_in,
	input wire chain1_serial_in,
	input wire chain2_serial_in,
	output reg serial_data_out,
	output reg ext_chain_scan_out,
	output reg [3:0] port_state_out,
	output reg [CHAIN_LEN-1:0] chain_number_out,
	output reg [IR_LEN-1:0] current_instr_out,
	output reg cells_test_mode,
	output reg debug_exit_pulse
);

	// Select values for the data register path.
	localparam [2:0] DR_BYPASS = `TAPD_DR_BYPASS;
	localparam [2:0] DR_IDENT = `TAPD_DR_IDENT;
	localparam [2:0] DR_CHAIN_SEL = `TAPD_DR_CHAIN_SEL;
	localparam [2:0] DR_CHAIN1 = `TAPD_DR_CHAIN1;
	localparam [2:0] DR_CHAIN2 = `TAPD_DR_CHAIN2;
	localparam [2:0] DR_EXT = `TAPD_DR_EXT;

	// The test reset pin is treated as a synchronous level, like every other input.
	// R23 reset pulse
	wire port_reset = srst | ~test_reset_n;
	// R6 enabled edges
	wire step = debug_clock_enable;

	reg [3:0] state_nxt;
	reg [IR_LEN-1:0] instr_shift_r;
	reg bypass_r;
	reg [ID_LEN-1:0] ident_shift_r;
	reg [CHAIN_LEN-1:0] chain_shift_r;
	reg [2:0] dr_path;
	reg chain_bit;

	// An edge leaving update-instruction installs the shifted code, so restart must look at it.
	wire [IR_LEN-1:0] instr_after = (port_state_out == `TAPD_ST_UPDATE_IR) ?
		instr_shift_r : current_instr_out;

	// Whether a chain number reaches the external chain pins.
	function ext_chain_num;
		input [CHAIN_LEN-1:0] num;
		begin
			// R25 external chain numbers
			ext_chain_num = (num == `TAPD_CHAIN_EXT) || num[`TAPD_CHAIN_UNASSIGNED_MSB];
		end
	endfunction

	// Data register behind an instruction, given the active chain number.
	function [2:0] dr_decode;
		input [IR_LEN-1:0] instr;
		input [CHAIN_LEN-1:0] num;
		begin
			case (instr)
			`TAPD_IR_EXTEST: begin
				// R7 external boundary chain
				dr_decode = DR_EXT;
			end
			`TAPD_IR_SAMPLE: begin
				// The boundary register sits on the external chain, so preload goes there.
				dr_decode = DR_EXT;
			end
			`TAPD_IR_SCAN_SEL: begin
				// R9 chain-select path
				dr_decode = DR_CHAIN_SEL;
			end
			`TAPD_IR_INTEST: begin
				// R11 selected chain
				if (num == `TAPD_CHAIN_DEBUG) begin
					dr_decode = DR_CHAIN1;
				end else if (num == `TAPD_CHAIN_ICE) begin
					dr_decode = DR_CHAIN2;
				// R22 external chains in test
				end else if (ext_chain_num(num)) begin
					dr_decode = DR_EXT;
				end else begin
					// Reserved chain numbers have no chain, so bypass keeps the path defined.
					dr_decode = DR_BYPASS;
				end
			end
			`TAPD_IR_IDCODE: begin
				// R13 identification path
				dr_decode = DR_IDENT;
			end
			default: begin
				// R17 unassigned codes
				// R18 restart as bypass
				dr_decode = DR_BYPASS;
			end
			endcase
		end
	endfunction

	// R26 controller transitions
	always @* begin
		case (port_state_out)
		`TAPD_ST_TEST_RESET: begin
			state_nxt = mode_select_in ? `TAPD_ST_TEST_RESET : `TAPD_ST_RUN_IDLE;
		end
		`TAPD_ST_RUN_IDLE: begin
			state_nxt = mode_select_in ? `TAPD_ST_SEL_DR : `TAPD_ST_RUN_IDLE;
		end
		`TAPD_ST_SEL_DR: begin
			state_nxt = mode_select_in ? `TAPD_ST_SEL_IR : `TAPD_ST_CAPTURE_DR;
		end
		`TAPD_ST_CAPTURE_DR: begin
			state_nxt = mode_select_in ? `TAPD_ST_EXIT1_DR : `TAPD_ST_SHIFT_DR;
		end
		`TAPD_ST_SHIFT_DR: begin
			state_nxt = mode_select_in ? `TAPD_ST_EXIT1_DR : `TAPD_ST_SHIFT_DR;
		end
		`TAPD_ST_EXIT1_DR: begin
			state_nxt = mode_select_in ? `TAPD_ST_UPDATE_DR : `TAPD_ST_PAUSE_DR;
		end
		`TAPD_ST_PAUSE_DR: begin
			state_nxt = mode_select_in ? `TAPD_ST_EXIT2_DR : `TAPD_ST_PAUSE_DR;
		end
		`TAPD_ST_EXIT2_DR: begin
			state_nxt = mode_select_in ? `TAPD_ST_UPDATE_DR : `TAPD_ST_SHIFT_DR;
		end
		`TAPD_ST_UPDATE_DR: begin
			state_nxt = mode_select_in ? `TAPD_ST_SEL_DR : `TAPD_ST_RUN_IDLE;
		end
		`TAPD_ST_SEL_IR: begin
			state_nxt = mode_select_in ? `TAPD_ST_TEST_RESET : `TAPD_ST_CAPTURE_IR;
		end
		`TAPD_ST_CAPTURE_IR: begin
			state_nxt = mode_select_in ? `TAPD_ST_EXIT1_IR : `TAPD_ST_SHIFT_IR;
		end
		`TAPD_ST_SHIFT_IR: begin
			state_nxt = mode_select_in ? `TAPD_ST_EXIT1_IR : `TAPD_ST_SHIFT_IR;
		end
		`TAPD_ST_EXIT1_IR: begin
			state_nxt = mode_select_in ? `TAPD_ST_UPDATE_IR : `TAPD_ST_PAUSE_IR;
		end
		`TAPD_ST_PAUSE_IR: begin
			state_nxt = mode_select_in ? `TAPD_ST_EXIT2_IR : `TAPD_ST_PAUSE_IR;
		end
		`TAPD_ST_EXIT2_IR: begin
			state_nxt = mode_select_in ? `TAPD_ST_UPDATE_IR : `TAPD_ST_SHIFT_IR;
		end
		`TAPD_ST_UPDATE_IR: begin
			state_nxt = mode_select_in ? `TAPD_ST_SEL_DR : `TAPD_ST_RUN_IDLE;
		end
		default: begin
			state_nxt = `TAPD_ST_TEST_RESET;
		end
		endcase
	end

	// Path and serial bit of the selected data register.
	always @* begin
		dr_path = dr_decode(current_instr_out, chain_number_out);
		case (dr_path)
		DR_IDENT: begin
			chain_bit = ident_shift_r[0];
		end
		DR_CHAIN_SEL: begin
			chain_bit = chain_shift_r[0];
		end
		DR_CHAIN1: begin
			chain_bit = chain1_serial_in;
		end
		DR_CHAIN2: begin
			chain_bit = chain2_serial_in;
		end
		DR_EXT: begin
			chain_bit = ext_chain_scan_in;
		end
		default: begin
			chain_bit = bypass_r;
		end
		endcase
	end

	// Controller state, presented directly as the state output.
	always @(posedge mclk) begin
		if (port_reset) begin
			port_state_out <= `TAPD_ST_TEST_RESET;
		end else if (step) begin
			// R24 state output
			port_state_out <= state_nxt;
		end
	end

	// Instruction shift register and current instruction.
	always @(posedge mclk) begin
		if (port_reset) begin
			instr_shift_r <= `TAPD_IR_CAPTURE;
			// R5 identification on reset
			current_instr_out <= `TAPD_IR_RESET;
		end else if (step) begin
			case (port_state_out)
			`TAPD_ST_CAPTURE_IR: begin
				// R1 four-bit register
				// R2 capture pattern
				instr_shift_r <= `TAPD_IR_CAPTURE;
			end
			`TAPD_ST_SHIFT_IR: begin
				// R3 instruction shift
				instr_shift_r <= {serial_data_in, instr_shift_r[IR_LEN-1:1]};
			end
			`TAPD_ST_UPDATE_IR: begin
				// R4 instruction update
				current_instr_out <= instr_shift_r;
			end
			`TAPD_ST_TEST_RESET: begin
				current_instr_out <= `TAPD_IR_RESET;
			end
			default: begin
				instr_shift_r <= instr_shift_r;
			end
			endcase
		end
	end

	// Bypass, identification and chain-select registers.
	always @(posedge mclk) begin
		if (port_reset) begin
			bypass_r <= `TAPD_BYPASS_CAPTURE;
			ident_shift_r <= {ID_LEN{1'b0}};
			chain_shift_r <= `TAPD_CHAIN_CAPTURE;
			chain_number_out <= `TAPD_CHAIN_RESET;
		end else if (step) begin
			if (port_state_out == `TAPD_ST_CAPTURE_DR) begin
				if (dr_path == DR_BYPASS) begin
					// R16 bypass captures zero
					bypass_r <= `TAPD_BYPASS_CAPTURE;
				end
				if (dr_path == DR_IDENT) begin
					// R14 identification capture
					ident_shift_r <= ident_value_in;
				end
				if (dr_path == DR_CHAIN_SEL) begin
					chain_shift_r <= `TAPD_CHAIN_CAPTURE;
				end
			end
			// R20 one bit per enabled clock
			if (port_state_out == `TAPD_ST_SHIFT_DR) begin
				if (dr_path == DR_BYPASS) begin
					bypass_r <= serial_data_in;
				end
				// R15 shifted-in identification data goes nowhere
				if (dr_path == DR_IDENT) begin
					ident_shift_r <= {serial_data_in, ident_shift_r[ID_LEN-1:1]};
				end
				if (dr_path == DR_CHAIN_SEL) begin
					chain_shift_r <= {serial_data_in, chain_shift_r[CHAIN_LEN-1:1]};
				end
			end
			// R10 chain becomes active
			if (port_state_out == `TAPD_ST_UPDATE_DR && dr_path == DR_CHAIN_SEL) begin
				chain_number_out <= chain_shift_r;
			end
		end
	end

	// Serial data out and the forwarded data-in for the scan chains.
	always @(posedge mclk) begin
		if (port_reset) begin
			serial_data_out <= 1'b0;
			ext_chain_scan_out <= 1'b0;
		end else begin
			// Forwarding on every clock keeps the chains fed whatever the enable pattern.
			ext_chain_scan_out <= serial_data_in;
			if (step) begin
				// R3 instruction bits out
				if (port_state_out == `TAPD_ST_SHIFT_IR) begin
					serial_data_out <= instr_shift_r[0];
				// R12 captured data out
				end else if (port_state_out == `TAPD_ST_SHIFT_DR) begin
					serial_data_out <= chain_bit;
				end
			end
		end
	end

	// Scan cell mode and the debug exit request.
	always @(posedge mclk) begin
		if (port_reset) begin
			cells_test_mode <= 1'b0;
			debug_exit_pulse <= 1'b0;
		end else begin
			// R11 cells in test mode
			// R13 system mode otherwise
			cells_test_mode <= (current_instr_out == `TAPD_IR_INTEST);
			// R19 leave debug on idle entry
			debug_exit_pulse <= step && (instr_after == `TAPD_IR_RESTART) &&
				(state_nxt == `TAPD_ST_RUN_IDLE) &&
				(port_state_out != `TAPD_ST_RUN_IDLE);
		end
	end

endmodule

`default_nettype wire

// ### dv/tapd_port_checker.sv
// Assertions on the test access port outputs.
// Bound to every tapd_port instance; sees only its ports.
`default_nettype none
module tapd_port_checker #(
	parameter IR_LEN = 4,
	parameter CHAIN_LEN = 5
) (
	input wire logic mclk,
	input wire logic srst,
	input wire logic test_reset_n,
	input wire logic debug_clock_enable,
	input wire logic mode_select_in,
	input wire logic serial_data_out,
	input wire logic [3:0] port_state_out,
	input wire logic [CHAIN_LEN-1:0] chain_number_out,
	input wire logic [IR_LEN-1:0] current_instr_out,
	input wire logic cells_test_mode,
	input wire logic debug_exit_pulse
);
	timeunit 1ns;
	timeprecision 1ns;
	wire en = debug_clock_enable;
	wire [3:0] st = port_state_out;
	wire live = !srst && test_reset_n;
	default clocking @(posedge mclk); endclocking
	default disable iff (srst || !test_reset_n);
	sequence s_sel_ir;
		en && st == 4'h4 && !mode_select_in;
	endsequence
	sequence s_cap_ir;
		en && st == 4'he && !mode_select_in;
	endsequence
	AST_RESET: assert property (disable iff (1'b0) (srst || !test_reset_n) |=>
		st == 4'hf && current_instr_out == 4'he && chain_number_out == 5'h03)
		else $error("reset values wrong");
	AST_IR_PATH: assert property (s_sel_ir ##[1:2] s_cap_ir |=> st == 4'ha)
		else $error("capture-instruction did not lead to shift");
	AST_DIS_HOLD: assert property (live && !en |=> $stable(st) && $stable(serial_data_out) &&
		$stable(current_instr_out) && $stable(chain_number_out))
		else $error("output moved on a disabled cycle");
	AST_TDO: assert property (live && en && st != 4'h2 && st != 4'ha |=>
		$stable(serial_data_out))
		else $error("data out moved outside shift");
	AST_INSTR: assert property (live && en && st != 4'hd && st != 4'hf |=>
		$stable(current_instr_out))
		else $error("instruction changed outside update");
	AST_TLR: assert property (en && st == 4'hf |=> current_instr_out == 4'he)
		else $error("test reset state did not select identification");
	AST_CHAIN: assert property (live && !(en && st == 4'h5 && current_instr_out == 4'h2) |=>
		$stable(chain_number_out))
		else $error("chain number changed without chain select update");
	AST_TMODE: assert property (live |=>
		cells_test_mode == ($past(current_instr_out) == 4'hc))
		else $error("test mode does not follow internal test");
	AST_PULSE: assert property (debug_exit_pulse |->
		st == 4'hc && current_instr_out == 4'h4 ##1 !debug_exit_pulse)
		else $error("debug exit pulse wrong");
	AST_IDLE: assert property (en && st == 4'hc && mode_select_in |=> st == 4'h7)
		else $error("idle did not advance to select data");
endmodule
bind tapd_port tapd_port_checker #(.IR_LEN(IR_LEN), .CHAIN_LEN(CHAIN_LEN)) chk (.*);
`default_nettype wire

// ### dv/tapd_ext_chain.sv
// Model of one external scan chain hung on the chain ports.
// Captures a fixed pattern, then shifts on enabled shift-data cycles.
`default_nettype none
module tapd_ext_chain #(
	parameter logic [7:0] CAP = 8'ha5
) (
	input wire logic mclk,
	input wire logic en,
	input wire logic [3:0] state,
	input wire logic sin,
	output logic sout
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] sr = 8'h00;
	assign sout = sr[0];
	always @(posedge mclk) begin
		if (en && state == 4'h6)
			sr <= CAP;
		else if (en && state == 4'h2)
			sr <= {sin, sr[7:1]};
	end
endmodule
`default_nettype wire

// ### dv/tapd_port_test.sv
// Self-checking bench for the test access port.
// Drives the port as a debugger would; a chain model closes the external loop.
`default_nettype none
module tapd_port_test;
	timeunit 1ns;
	timeprecision 1ns;
	// bit zero one; the value itself is arbitrary.
	localparam logic [31:0] IDV = 32'h5a3c_9671;
	logic mclk = 1'b0, srst = 1'b1, test_reset_n = 1'b1, debug_clock_enable = 1'b0;
	logic serial_data_in = 1'b0, mode_select_in = 1'b1, ext_in, tdo_q;
	logic serial_data_out, ext_out, cells_test_mode, debug_exit_pulse;
	logic [3:0] port_state_out, current_instr_out;
	logic [4:0] chain_number_out;
	logic [31:0] dout;
	logic [3:0] byp [11] = '{4'hf, 4'h4, 4'h1, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'ha, 4'hb, 4'hd};
	logic [4:0] cn [5] = '{5'h01, 5'h02, 5'h10, 5'h00, 5'h1f};
	logic [7:0] ce [5] = '{8'hff, 8'h00, 8'ha5, 8'hfe, 8'ha5};
	int err_count = 0, n_compared = 0, pulses = 0, p0 = 0;
	always #25 mclk = ~mclk;
	always @(posedge mclk) begin
		if (debug_exit_pulse === 1'b1)
			pulses <= pulses + 1;
	end
	tapd_port dut (.mclk(mclk), .srst(srst), .test_reset_n(test_reset_n),
		.debug_clock_enable(debug_clock_enable), .serial_data_in(serial_data_in),
		.mode_select_in(mode_select_in), .ident_value_in(IDV), .ext_chain_scan_in(ext_in),
		.chain1_serial_in(1'b1), .chain2_serial_in(1'b0), .serial_data_out(serial_data_out),
		.ext_chain_scan_out(ext_out), .port_state_out(port_state_out),
		.chain_number_out(chain_number_out), .current_instr_out(current_instr_out),
		.cells_test_mode(cells_test_mode), .debug_exit_pulse(debug_exit_pulse));
	tapd_ext_chain ext (.mclk(mclk), .en(debug_clock_enable), .state(port_state_out),
		.sin(ext_out), .sout(ext_in));
	task automatic end_of_test();
		$display("compared %0d, mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, exp);
		n_compared++;
		if (got !== exp) begin
			err_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// One enabled port step; the enable gap in between must leave the port still.
	task automatic step(input logic t, d);
		@(posedge mclk);
		mode_select_in <= t;
		serial_data_in <= d;
		debug_clock_enable <= 1'b1;
		@(posedge mclk);
		debug_clock_enable <= 1'b0;
		@(negedge mclk);
		tdo_q = serial_data_out;
	endtask
	task automatic ir(input logic [3:0] c);
		step(1, 0);
		step(1, 0);
		step(0, 0);
		step(0, 0);
		for (int i = 0; i < 4; i++) begin
			step(i == 3, c[i]);
			chk(tdo_q, i == 0);
		end
		step(1, 0);
		step(0, 0);
		chk(current_instr_out, c);
	endtask
	task automatic dr(input int n, input logic [31:0] din);
		dout = '0;
		step(1, 0);
		step(0, 0);
		step(0, 0);
		for (int i = 0; i < n; i++) begin
			step(i == n - 1, din[i]);
			dout[i] = tdo_q;
		end
		step(1, 0);
		step(0, 0);
	endtask
	initial begin
		repeat (20000) @(posedge mclk);
		err_count++;
		end_of_test();
	end
	initial begin
		repeat (10) @(posedge mclk);
		srst <= 1'b0;
		@(negedge mclk);
		chk(port_state_out, 4'hf);
		chk(current_instr_out, 4'he);
		chk(chain_number_out, 5'h03);
		step(0, 0);
		dr(32, 32'hffff_ffff);
		chk(dout, IDV);
		dr(32, 32'h0000_0000);
		chk(dout, IDV);
		foreach (byp[i]) begin
			ir(byp[i]);
			@(negedge mclk);
			p0 = pulses;
			dr(4, 32'h0000_000b);
			chk(dout, 32'h0000_0006);
			@(negedge mclk);
			chk(pulses - p0, byp[i] == 4'h4);
			chk(cells_test_mode, 1'b0);
		end
		foreach (cn[i]) begin
			ir(4'h2);
			dr(5, cn[i]);
			chk(dout, 32'h0000_0010);
			chk(chain_number_out, cn[i]);
			ir(4'hc);
			@(negedge mclk);
			chk(cells_test_mode, 1'b1);
			dr(8, 32'h0000_00ff);
			chk(dout, ce[i]);
		end
		for (int i = 0; i < 2; i++) begin
			ir(i ? 4'h0 : 4'h3);
			dr(8, 32'h0000_00ff);
			chk(dout, 32'h0000_00a5);
		end
		@(posedge mclk);
		test_reset_n <= 1'b0;
		@(posedge mclk);
		test_reset_n <= 1'b1;
		@(negedge mclk);
		chk(current_instr_out, 4'he);
		chk(chain_number_out, 5'h03);
		// Data-in reaches the external chains one clock later.
		@(posedge mclk);
		serial_data_in <= 1'b1;
		@(posedge mclk);
		@(negedge mclk);
		chk(ext_out, 1'b1);
		end_of_test();
	end
endmodule
`default_nettype wire
